// ---- design/tkcfg_pkg.sv ----
// Package for the touch key module configuration register bank.
// Assumes an APB master with 32-bit data and word-aligned registers.
package tkcfg_pkg;
    localparam int unsigned NUM_MODULES = 4;
    localparam int unsigned ADDR_W = 8;
    // Per-module block: four words, modules 0x10 bytes apart
    localparam logic [7:0] OFS_CAP_HIGH = 8'h00;
    localparam logic [7:0] OFS_CAP_LOW = 8'h04;
    localparam logic [7:0] OFS_CTRL_ZERO = 8'h08;
    localparam logic [7:0] OFS_CTRL_ONE = 8'h0C;
    localparam logic [7:0] MODULE_STRIDE = 8'h10;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CAP_HIGH_MASK = 8'h03;
    localparam logic [7:0] CTRL_ONE_MASK = 8'hBF;
    localparam int unsigned CAP_CODE_W = 10;
    // Capacitance = code * CAP_FULL_PF / CAP_DIVISOR
    localparam int unsigned CAP_FULL_PF = 50;
    localparam int unsigned CAP_DIVISOR = 1024;
    localparam int unsigned SLOT_CLK_DIV = 4;
    localparam logic [1:0] SLOT_DIV_LAST = 2'h3;

    typedef enum logic [1:0] {
        TKCFG_IDLE = 2'b00,
        TKCFG_ACCESS = 2'b01
    } tkcfg_state_e;

    // Configuration one module hands to its analog front end
    typedef struct packed {
        logic [9:0] ref_osc_cap_code;
        logic [1:0] key_mux_select;
        logic freq_double_enable;
        logic filter_enable;
        logic hop_control_select;
        logic [2:0] hop_freq_select;
        logic hop_by_hardware;
        logic slot_clock_select;
        logic slot_clock;
        logic ref_osc_enable;
        logic key_osc_enable;
        logic [3:0] key_pin_enable;
    } tkcfg_module_s;
endpackage : tkcfg_pkg

// ---- design/tkcfg_bank.sv ----
// Register bank holding four touch key module configurations over APB.
// Assumes clk is the system clock; pads and oscillators read the outputs.
`timescale 1ns/1ps
module tkcfg_bank #(
    parameter int unsigned MODULES = tkcfg_pkg::NUM_MODULES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output tkcfg_pkg::tkcfg_module_s [MODULES-1:0] module_cfg
);
    // A 4-bit module field in the address could map 16 modules; the check stops at 15
    if (MODULES < 1 || MODULES > 15) begin : g_bad_modules
        $error("tkcfg_bank: MODULES must be 1 to 15");
    end

    logic rst_meta_b;
    logic rst_sync_b;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // One clock domain, so every property shares this clock and reset
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_sync_b);

    logic [7:0] cap_high [MODULES];
    logic [7:0] cap_low [MODULES];
    logic [7:0] ctrl_zero [MODULES];
    logic [7:0] ctrl_one [MODULES];
    logic [7:0] next_cap_high [MODULES];
    logic [7:0] next_cap_low [MODULES];
    logic [7:0] next_ctrl_zero [MODULES];
    logic [7:0] next_ctrl_one [MODULES];
    tkcfg_pkg::tkcfg_state_e state;
    tkcfg_pkg::tkcfg_state_e next_state;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [1:0] slot_div;
    logic [1:0] next_slot_div;
    tkcfg_pkg::tkcfg_module_s [MODULES-1:0] next_cfg;

    // Module index of an address, or MODULES when unmapped
    function automatic int unsigned addr_module(input logic [7:0] a);
        int unsigned m;
        m = int'(a[7:4]);
        if (a[1:0] != 2'h0 || m >= MODULES) begin
            m = MODULES;
        end
        return m;
    endfunction : addr_module

    // Byte lane 0 update with strobe and writable-bit mask
    function automatic logic [7:0] lane_write(input logic [7:0] old,
            input logic [7:0] wd, input logic [7:0] mask, input logic en);
        logic [7:0] r;
        r = en ? ((old & ~mask) | (wd & mask)) : old;
        return r;
    endfunction : lane_write

    int unsigned sel_mod;
    logic [7:0] sel_ofs;
    always_comb begin
        sel_mod = addr_module(paddr);
        sel_ofs = paddr & 8'h0F;
        next_state = state;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        for (int m = 0; m < MODULES; m++) begin
            next_cap_high[m] = cap_high[m];
            next_cap_low[m] = cap_low[m];
            next_ctrl_zero[m] = ctrl_zero[m];
            next_ctrl_one[m] = ctrl_one[m];
        end
        case (state)
            tkcfg_pkg::TKCFG_IDLE: begin
                // Answer one cycle into the access phase
                if (psel && penable) begin
                    next_state = tkcfg_pkg::TKCFG_ACCESS;
                    next_pready = 1'b1;
                    if (sel_mod == MODULES) begin
                        next_pslverr = 1'b1;
                    end else if (!pwrite) begin
                        // Writes land one edge later, when pready is seen
                        case (sel_ofs)
                            tkcfg_pkg::OFS_CAP_HIGH:
                                next_prdata[7:0] = cap_high[sel_mod];
                            tkcfg_pkg::OFS_CAP_LOW:
                                next_prdata[7:0] = cap_low[sel_mod];
                            tkcfg_pkg::OFS_CTRL_ZERO:
                                next_prdata[7:0] = ctrl_zero[sel_mod];
                            tkcfg_pkg::OFS_CTRL_ONE:
                                next_prdata[7:0] = ctrl_one[sel_mod];
                            default: next_prdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            tkcfg_pkg::TKCFG_ACCESS: begin
                next_state = tkcfg_pkg::TKCFG_IDLE;
            end
            default: next_state = tkcfg_pkg::TKCFG_IDLE;
        endcase
        // Write lands on the edge where pready is sampled high
        if (state == tkcfg_pkg::TKCFG_ACCESS && psel && penable && pwrite
                && pready && !pslverr && sel_mod != MODULES) begin
            case (sel_ofs)
                tkcfg_pkg::OFS_CAP_HIGH:
                    next_cap_high[sel_mod] = lane_write(cap_high[sel_mod],
                        pwdata[7:0], tkcfg_pkg::CAP_HIGH_MASK, pstrb[0]);
                tkcfg_pkg::OFS_CAP_LOW:
                    next_cap_low[sel_mod] = lane_write(cap_low[sel_mod],
                        pwdata[7:0], 8'hFF, pstrb[0]);
                tkcfg_pkg::OFS_CTRL_ZERO:
                    next_ctrl_zero[sel_mod] = lane_write(ctrl_zero[sel_mod],
                        pwdata[7:0], 8'hFF, pstrb[0]);
                tkcfg_pkg::OFS_CTRL_ONE:
                    // Bit 6 is unimplemented and stays zero
                    next_ctrl_one[sel_mod] = lane_write(ctrl_one[sel_mod],
                        pwdata[7:0], tkcfg_pkg::CTRL_ONE_MASK, pstrb[0]);
                default: next_ctrl_one[sel_mod] = ctrl_one[sel_mod];
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= tkcfg_pkg::TKCFG_IDLE;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            for (int m = 0; m < MODULES; m++) begin
                cap_high[m] <= tkcfg_pkg::RST_BYTE;
                cap_low[m] <= tkcfg_pkg::RST_BYTE;
                ctrl_zero[m] <= tkcfg_pkg::RST_BYTE;
                ctrl_one[m] <= tkcfg_pkg::RST_BYTE;
            end
        end else if (clk_en) begin
            state <= next_state;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            for (int m = 0; m < MODULES; m++) begin
                cap_high[m] <= next_cap_high[m];
                cap_low[m] <= next_cap_low[m];
                ctrl_zero[m] <= next_ctrl_zero[m];
                ctrl_one[m] <= next_ctrl_one[m];
            end
        end
    end

    // System clock divided by four for the time slot counter option
    always_comb begin
        next_slot_div = slot_div + 2'h1;
    end
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            slot_div <= 2'h0;
        end else if (clk_en) begin
            slot_div <= next_slot_div;
        end
    end

    // Outputs are registered so the analog side sees glitch-free levels
    always_comb begin
        for (int m = 0; m < MODULES; m++) begin
            next_cfg[m].ref_osc_cap_code =
                {cap_high[m][1:0], cap_low[m]};
            next_cfg[m].key_mux_select = ctrl_zero[m][7:6];
            next_cfg[m].freq_double_enable = ctrl_zero[m][5];
            next_cfg[m].filter_enable = ctrl_zero[m][4];
            next_cfg[m].hop_control_select = ctrl_zero[m][3];
            next_cfg[m].hop_by_hardware = ctrl_zero[m][3];
            // Field forced to zero while hardware owns hopping
            next_cfg[m].hop_freq_select =
                ctrl_zero[m][3] ? 3'h0 : ctrl_zero[m][2:0];
            next_cfg[m].slot_clock_select = ctrl_one[m][7];
            // High half of the divide-by-four period; the reference
            // oscillator path is muxed in the analog domain
            next_cfg[m].slot_clock =
                ctrl_one[m][7] & slot_div[1];
            next_cfg[m].ref_osc_enable = ctrl_one[m][5];
            next_cfg[m].key_osc_enable = ctrl_one[m][4];
            next_cfg[m].key_pin_enable = ctrl_one[m][3:0];
        end
    end
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            module_cfg <= '0;
        end else if (clk_en) begin
            module_cfg <= next_cfg;
        end
    end

    // Assertions watch module 0; the other modules share its logic
    a_cap_code_follow: assert property (
        clk_en |=> module_cfg[0].ref_osc_cap_code ==
            {$past(cap_high[0][1:0]), $past(cap_low[0])})
        else $error("capacitor code does not follow registers");
    a_cap_high_clear: assert property (
        cap_high[0][7:2] == 6'h00)
        else $error("unused capacitor bits set");
    a_mux_select: assert property (
        clk_en |=> module_cfg[0].key_mux_select == $past(ctrl_zero[0][7:6]))
        else $error("mux select mismatch");
    a_double_bit: assert property (
        clk_en |=> module_cfg[0].freq_double_enable == $past(ctrl_zero[0][5]))
        else $error("frequency double mismatch");
    a_filter_bit: assert property (
        clk_en |=> module_cfg[0].filter_enable == $past(ctrl_zero[0][4]))
        else $error("filter enable mismatch");
    a_hop_ignore: assert property (
        module_cfg[0].hop_by_hardware |->
            module_cfg[0].hop_freq_select == 3'h0)
        else $error("hop field not ignored under hardware control");
    a_hop_field: assert property (
        clk_en && !ctrl_zero[0][3] |=>
            module_cfg[0].hop_freq_select == $past(ctrl_zero[0][2:0]))
        else $error("hop field mismatch");
    a_slot_clock: assert property (
        !module_cfg[0].slot_clock_select |-> !module_cfg[0].slot_clock)
        else $error("divided clock active while reference selected");
    a_slot_divide: assert property (
        clk_en && ctrl_one[0][7] |=>
            module_cfg[0].slot_clock == $past(slot_div[1]))
        else $error("divided slot clock out of phase");
    a_osc_enables: assert property (
        clk_en |=> module_cfg[0].ref_osc_enable == $past(ctrl_one[0][5])
            && module_cfg[0].key_osc_enable == $past(ctrl_one[0][4]))
        else $error("oscillator enable mismatch");
    a_key_pins: assert property (
        clk_en |=> module_cfg[0].key_pin_enable == $past(ctrl_one[0][3:0]))
        else $error("key pin enable mismatch");
    a_spare_bit: assert property (
        ctrl_one[0][6] == 1'b0)
        else $error("unimplemented control bit set");
    a_write_lands: assert property (
        clk_en && state == tkcfg_pkg::TKCFG_ACCESS && psel && penable
            && pwrite && pstrb[0] && !pslverr
            && paddr == tkcfg_pkg::OFS_CTRL_ZERO
            |=> ctrl_zero[0] == $past(pwdata[7:0]))
        else $error("control write did not land");
    // Refused or unstrobed accesses must leave every register alone
    a_refused_write: assert property (
        state == tkcfg_pkg::TKCFG_ACCESS && pslverr |=>
            $stable(cap_high[0]) && $stable(cap_low[0])
            && $stable(ctrl_zero[0]) && $stable(ctrl_one[0]))
        else $error("refused access changed a register");
    a_strobe_guard: assert property (
        state == tkcfg_pkg::TKCFG_ACCESS && !pstrb[0] |=>
            $stable(cap_high[0]) && $stable(cap_low[0])
            && $stable(ctrl_zero[0]) && $stable(ctrl_one[0]))
        else $error("write with lane strobe low changed a register");
    a_ready_answer: assert property (
        clk_en && state == tkcfg_pkg::TKCFG_IDLE && psel && penable
            |=> pready)
        else $error("access phase not answered after one wait state");
    a_ready_pulse: assert property (
        pready && clk_en |=> !pready)
        else $error("pready held longer than one cycle");
    a_err_pulse: assert property (
        pslverr |-> pready)
        else $error("error response without ready");
    a_upper_zero: assert property (
        prdata[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    c_write_ok: cover property (
        psel && penable && pwrite && pready && !pslverr);
    c_read_ok: cover property (
        psel && penable && !pwrite && pready);
    c_bad_addr: cover property (
        pready && pslverr);
    c_hw_hop: cover property (
        module_cfg[0].hop_by_hardware);
    c_frozen: cover property (
        !clk_en && module_cfg[0].slot_clock_select);
endmodule : tkcfg_bank

// ---- bench/tkcfg_pads.sv ----
// Model of the touch pads and oscillators fed by the configuration bank.
// Assumes module_cfg levels come from the bank on the same system clock.
`timescale 1ns/1ps
module tkcfg_pads (
    input wire logic clk,
    input wire tkcfg_pkg::tkcfg_module_s [3:0] module_cfg,
    output logic [3:0][4:0] key_num,
    output logic [3:0][15:0] cap_ff,
    output logic [3:0][7:0] slot_rises
);
    logic [3:0] slot_q = 4'h0;
    logic [3:0][7:0] rise_cnt = '0;
    assign slot_rises = rise_cnt;
    // Pad that the mux connects, and reference capacitance in fF
    always_comb begin
        for (int m = 0; m < 4; m++) begin
            key_num[m] = 5'(4 * m + 1) + 5'(module_cfg[m].key_mux_select);
            cap_ff[m] = 16'((32'(module_cfg[m].ref_osc_cap_code) * 50000)
                / 1024);
        end
    end
    // The slot counter only sees rising edges, so count those
    always @(posedge clk) begin
        for (int m = 0; m < 4; m++) begin
            slot_q[m] <= module_cfg[m].slot_clock;
            if (module_cfg[m].slot_clock && !slot_q[m])
                rise_cnt[m] <= rise_cnt[m] + 8'h01;
        end
    end
endmodule : tkcfg_pads

// ---- bench/test_touch_key_module_config.sv ----
// Self-checking bench for the touch key configuration bank over APB.
// Assumes the pad model tkcfg_pads and a 200 MHz system clock.
`timescale 1ns/1ps
module test_touch_key_module_config;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tkcfg_pkg::tkcfg_module_s [3:0] module_cfg;
    logic [3:0][4:0] key_num;
    logic [3:0][15:0] cap_ff;
    logic [3:0][7:0] slot_rises;
    logic [7:0] exp_reg [4][4] = '{default: 8'h00};
    logic [31:0] rd;
    logic [31:0] rv;
    logic err;
    logic [7:0] rises;
    int seed = 32'h9A77;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    always #2.5 clk = ~clk;
    tkcfg_bank u_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .module_cfg(module_cfg));
    tkcfg_pads u_pads (.clk(clk), .module_cfg(module_cfg), .key_num(key_num),
        .cap_ff(cap_ff), .slot_rises(slot_rises));
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic tkcfg_pkg::tkcfg_module_s exp_cfg(input int m);
        logic [7:0] z;
        logic [7:0] o;
        z = exp_reg[m][2];
        o = exp_reg[m][3];
        return '{{exp_reg[m][0][1:0], exp_reg[m][1]}, z[7:6], z[5], z[4],
            z[3], z[3] ? 3'h0 : z[2:0], z[3], o[7], 1'b0, o[5], o[4],
            o[3:0]};
    endfunction : exp_cfg
    task automatic check_mod(input int m);
        tkcfg_pkg::tkcfg_module_s c;
        c = module_cfg[m];
        c.slot_clock = 1'b0;
        check("cfg", 32'(c), 32'(exp_cfg(m)));
        check("key", 32'(key_num[m]), 32'(4 * m + 1 + exp_reg[m][2][7:6]));
        check("cap", 32'(cap_ff[m]), (32'({exp_reg[m][0][1:0],
            exp_reg[m][1]}) * 50000) / 1024);
    endtask : check_mod
    task automatic get(input int m, input int r);
        apb(1'b0, 8'(m * 16 + r * 4), 32'h0, 4'h0);
        check("rd", rd, 32'(exp_reg[m][r]));
        check("rd_err", 32'(err), 32'h0);
    endtask : get
    task automatic put(input int m, input int r, input logic [7:0] d,
        input logic [3:0] s);
        apb(1'b1, 8'(m * 16 + r * 4), {rv[31:8], d}, s);
        check("wr_err", 32'(err), 32'h0);
        if (s[0])
            exp_reg[m][r] = d & (r == 0 ? 8'h03 : r == 3 ? 8'hBF : 8'hFF);
        repeat (2) @(posedge clk);
        check_mod(m);
    endtask : put
    task automatic slot_run(input logic [7:0] c1, input int n);
        put(0, 3, c1, 4'hF);
        // Skip the first divider period, whose left edge is not a real rise
        repeat (4) @(posedge clk);
        rises = slot_rises[0];
        repeat (40) @(posedge clk);
        check("slot", 32'(8'(slot_rises[0] - rises)), n);
    endtask : slot_run
    task automatic check_all;
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 4; r++)
                get(m, r);
            check_mod(m);
        end
    endtask : check_all
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end
    initial begin
        rv = 32'h0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        check_all();
        // Every mux and hop code, then the hardware hop override
        for (int i = 0; i < 8; i++)
            put(i % 4, 2, 8'({i[1:0], 3'b000, i[2:0]}), 4'hF);
        put(3, 2, 8'hFF, 4'hF);
        put(3, 2, 8'hF7, 4'hF);
        repeat (24) begin
            rv = $random(seed);
            put(rv[1:0], rv[3:2], rv[15:8], 4'hF);
            get(rv[1:0], rv[3:2]);
        end
        // Lane zero strobe low must leave the register alone
        put(1, 1, 8'h5A, 4'hE);
        get(1, 1);
        // Unmapped and unaligned places are refused without side effects
        apb(1'b1, 8'h40, 32'hFF, 4'hF);
        check("unmap_err", 32'(err), 32'h1);
        apb(1'b1, 8'h05, 32'hFF, 4'hF);
        check("unalign_err", 32'(err), 32'h1);
        apb(1'b0, 8'h41, 32'h0, 4'h0);
        check("unmap_rd", rd, 32'h0);
        get(0, 0);
        get(0, 1);
        slot_run(8'h80, 10);
        // Clock enable low freezes the divider and every register
        clk_en <= 1'b0;
        repeat (2) @(posedge clk);
        rises = slot_rises[0];
        repeat (8) @(posedge clk);
        check("freeze", 32'(8'(slot_rises[0] - rises)), 32'h0);
        check_mod(0);
        clk_en <= 1'b1;
        slot_run(8'h00, 0);
        // A reset in mid-run returns every register to zero
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        exp_reg = '{default: 8'h00};
        check_all();
        give_verdict();
    end
endmodule : test_touch_key_module_config
